// file: rtl/mpe_pkg.sv
package mpe_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CC_OFS = 8'h00;
  localparam logic [7:0] OS_OFS = 8'h04;
  localparam logic [7:0] EC_OFS = 8'h08;
  localparam logic [7:0] ES_OFS = 8'h0C;
  localparam logic [7:0] KEY_OFS = 8'h10;
  localparam logic [7:0] PM_OFS = 8'h14;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int CC_W = 11;
  localparam int CC_PWM_LSB = 8;
  localparam logic [10:0] CC_MASK = 11'h73F;
  localparam logic [10:0] CC_RST = 11'h000;
  localparam int OS_SYNC_LSB = 8;
  localparam int OS_POLH = 3;
  localparam int OS_POLL = 2;
  localparam int OS_PSYNC_LSB = 0;
  localparam int EC_EN = 0;
  localparam int EC_REL = 1;
  localparam int EC_MD_LSB = 3;
  localparam int EC_INH = 5;
  localparam logic EC_EN_RST = 1'b1;
  localparam logic EC_INH_RST = 1'b1;
  localparam logic [1:0] EC_MD_RST = 2'h3;
  localparam int ES_PROT = 0;
  localparam int ES_IN = 1;
  localparam int PM_MODE = 0;
  localparam logic [7:0] KEY_FIRST = 8'h5A;
  localparam logic [7:0] KEY_SECOND = 8'hA5;

  // ****************************************************************
  // Modes and states
  // ****************************************************************
  typedef enum logic [1:0] {
    PSY_ASYNC = 2'h0, PSY_BOTTOM = 2'h1, PSY_PEAK = 2'h2, PSY_BOTH = 2'h3
  } mpe_psync_t;
  typedef enum logic [1:0] {
    TRG_NONE = 2'h0, TRG_A = 2'h1, TRG_B = 2'h2, TRG_RSVD = 2'h3
  } mpe_trig_t;
  typedef enum logic [1:0] {
    EMD_ALL_Z0 = 2'h0, EMD_UP_ON = 2'h1, EMD_LO_ON = 2'h2, EMD_ALL_Z = 2'h3
  } mpe_emd_t;
  typedef enum logic [2:0] {
    KEY_IDLE = 3'h1, KEY_HALF = 3'h2, KEY_OPEN = 3'h4
  } mpe_key_t;
  typedef enum logic [1:0] {
    PROT_NORMAL = 2'h1, PROT_ACTIVE = 2'h2
  } mpe_prot_t;

endpackage

// file: rtl/mpe_phase_map.sv
`timescale 1ns/1ps
module mpe_phase_map (
  // Applied conduction setting
  input wire logic [10:0] cc,
  // Polarity
  input wire logic polh,
  input wire logic poll,
  // Raw waveforms from the carrier
  input wire logic [2:0] pwm_up,
  input wire logic [2:0] pwm_lo,
  // Pin levels
  output logic [2:0] lvl_up,
  output logic [2:0] lvl_lo
);
  import mpe_pkg::*;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      logic sel_pwm;
      logic [1:0] oc;
      logic act_up;
      logic act_lo;
      assign sel_pwm = cc[CC_PWM_LSB + g];
      assign oc = cc[2 * g +: 2];
      // Code 01 mutes the upper side, 10 the lower side
      assign act_up = sel_pwm ? (oc != 2'h1) && pwm_up[g] : oc[1];
      assign act_lo = sel_pwm ? (oc != 2'h2) && pwm_lo[g] : oc[0];
      assign lvl_up[g] = polh ? act_up : ~act_up;
      assign lvl_lo[g] = poll ? act_lo : ~act_lo;
    end
  endgenerate

endmodule

// file: rtl/mpe_key_lock.sv
`timescale 1ns/1ps
module mpe_key_lock (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus events
  input wire logic key_wr,
  input wire logic other_wr,
  input wire logic [7:0] key_data,
  input wire logic ovv_used,
  // State
  output logic unlocked
);
  import mpe_pkg::*;

  typedef struct packed {
    mpe_key_t st;
  } mpe_key_state_t;

  mpe_key_state_t s;
  mpe_key_state_t n;

  // Any other write breaks or spends the sequence, so one unlock serves one disable
  always_comb begin
    n = s;
    case (s.st)
      KEY_IDLE: begin
        if (key_wr && key_data == KEY_FIRST) begin
          n.st = KEY_HALF;
        end
      end
      KEY_HALF: begin
        if (key_wr) begin
          n.st = (key_data == KEY_SECOND) ? KEY_OPEN :
                 (key_data == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
        end else if (other_wr) begin
          n.st = KEY_IDLE;
        end
      end
      KEY_OPEN: begin
        if (key_wr) begin
          n.st = (key_data == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
        end else if (other_wr || ovv_used) begin
          n.st = KEY_IDLE;
        end
      end
      default: n.st = KEY_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s.st <= KEY_IDLE;
    end else begin
      s <= n;
    end
  end

  assign unlocked = (s.st == KEY_OPEN);

endmodule

// file: rtl/mpe_top.sv
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module mpe_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [mpe_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mpe_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [mpe_pkg::DATA_W-1:0] reg_rdata,
  // Carrier timing and waveforms
  input wire logic pwm_run,
  input wire logic carrier_bottom,
  input wire logic carrier_peak,
  input wire logic update_trigger_a,
  input wire logic update_trigger_b,
  input wire logic [2:0] pwm_upper,
  input wire logic [2:0] pwm_lower,
  // Protection inputs
  input wire logic emergency_stop_input_n,
  input wire logic tool_break,
  input wire logic ovv_key_used,
  // Phase outputs, order w v u from msb
  output logic [2:0] upper_out,
  output logic [2:0] upper_oe,
  output logic [2:0] lower_out,
  output logic [2:0] lower_oe,
  // Events and shared key state
  output logic emergency_interrupt,
  output logic key_unlocked
);
  import mpe_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [10:0] cc1;
    logic [10:0] cc2;
    logic trig_armed;
    logic [1:0] syncs;
    logic [1:0] psyncs;
    logic polh;
    logic poll;
    logic en;
    logic inhen;
    logic [1:0] emd;
    logic pmode;
    mpe_prot_t prot;
    logic emg_prev;
    logic irq;
    logic [31:0] rdata;
    logic [2:0] up_out;
    logic [2:0] up_oe;
    logic [2:0] lo_out;
    logic [2:0] lo_oe;
  } mpe_state_t;

  mpe_state_t s;
  mpe_state_t n;

  logic wr_cc;
  logic wr_os;
  logic wr_ec;
  logic wr_key;
  logic wr_pm;
  logic other_wr;
  logic unlocked;
  logic trig_hit;
  logic armed_now;
  logic at_point;
  logic load;
  logic fall;
  logic enter;
  logic release_ok;
  logic [2:0] lvl_up;
  logic [2:0] lvl_lo;

  // ****************************************************************
  // Submodules
  // ****************************************************************
  mpe_key_lock u_key (
    .sys_clk(sys_clk),
    .rst(rst),
    .key_wr(wr_key),
    .other_wr(other_wr),
    .key_data(reg_wdata[7:0]),
    .ovv_used(ovv_key_used),
    .unlocked(unlocked)
  );

  mpe_phase_map u_map (
    .cc(s.cc2),
    .polh(s.polh),
    .poll(s.poll),
    .pwm_up(pwm_upper),
    .pwm_lo(pwm_lower),
    .lvl_up(lvl_up),
    .lvl_lo(lvl_lo)
  );

  // ****************************************************************
  // Decode
  // ****************************************************************
  assign wr_cc = reg_wr && reg_addr == CC_OFS;
  assign wr_os = reg_wr && reg_addr == OS_OFS;
  assign wr_ec = reg_wr && reg_addr == EC_OFS;
  assign wr_key = reg_wr && reg_addr == KEY_OFS;
  assign wr_pm = reg_wr && reg_addr == PM_OFS;
  assign other_wr = reg_wr && !wr_key;

  // ****************************************************************
  // Second-stage load point
  // ****************************************************************
  assign trig_hit = (s.syncs == TRG_A && update_trigger_a) ||
                    (s.syncs == TRG_B && update_trigger_b);
  // Reserved trigger code behaves as no trigger so the buffer never sticks
  assign armed_now = s.syncs == TRG_NONE || s.syncs == TRG_RSVD ||
                     s.trig_armed || trig_hit;

  always_comb begin
    case (s.psyncs)
      PSY_ASYNC: at_point = 1'b1;
      PSY_BOTTOM: at_point = carrier_bottom;
      PSY_PEAK: at_point = carrier_peak;
      PSY_BOTH: at_point = carrier_bottom || carrier_peak;
      default: at_point = 1'b1;
    endcase
  end

  // A stopped carrier loads at once
  assign load = !pwm_run || (armed_now && at_point);

  // ****************************************************************
  // Emergency events
  // ****************************************************************
  assign fall = s.emg_prev && !emergency_stop_input_n;
  assign enter = s.en && fall;
  assign release_ok = wr_ec && reg_wdata[EC_REL] && emergency_stop_input_n &&
                      s.cc1 == CC_RST && s.cc2 == CC_RST;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n = s;
    n.emg_prev = emergency_stop_input_n;
    n.irq = 1'b0;
    n.rdata = '0;

    // Register writes
    if (wr_cc) begin
      n.cc1 = reg_wdata[CC_W-1:0] & CC_MASK;
    end
    if (wr_os) begin
      n.syncs = reg_wdata[OS_SYNC_LSB +: 2];
      n.polh = reg_wdata[OS_POLH];
      n.poll = reg_wdata[OS_POLL];
      n.psyncs = reg_wdata[OS_PSYNC_LSB +: 2];
    end
    if (wr_ec) begin
      n.emd = reg_wdata[EC_MD_LSB +: 2];
      n.inhen = reg_wdata[EC_INH];
      if (reg_wdata[EC_EN] || unlocked) begin
        n.en = reg_wdata[EC_EN];
      end
    end
    if (wr_pm) begin
      n.pmode = reg_wdata[PM_MODE];
    end

    // Double buffer
    if (load) begin
      n.cc2 = s.cc1;
      n.trig_armed = 1'b0;
    end else if (trig_hit) begin
      n.trig_armed = 1'b1;
    end
    if (!pwm_run) begin
      n.trig_armed = 1'b0;
    end

    // Protection state; entry wins over a release in the same cycle
    case (s.prot)
      PROT_NORMAL: begin
        if (enter) begin
          n.prot = PROT_ACTIVE;
          n.irq = 1'b1;
        end
      end
      PROT_ACTIVE: begin
        if (release_ok && !enter) begin
          n.prot = PROT_NORMAL;
        end
      end
      default: n.prot = PROT_NORMAL;
    endcase

    // Outputs
    n.up_out = lvl_up;
    n.lo_out = lvl_lo;
    n.up_oe = '1;
    n.lo_oe = '1;
    if (s.inhen && tool_break) begin
      if (s.pmode) begin
        n.up_oe = '0;
        n.lo_oe = '0;
      end else begin
        n.up_out = {3{~s.polh}};
        n.lo_out = {3{~s.poll}};
      end
    end
    // Decided from the next state so the outputs drop on the entry edge
    if (n.prot == PROT_ACTIVE) begin
      case (s.emd)
        EMD_UP_ON: n.lo_oe = '0;
        EMD_LO_ON: n.up_oe = '0;
        default: begin
          n.up_oe = '0;
          n.lo_oe = '0;
        end
      endcase
    end

    // Read data
    if (reg_rd) begin
      case (reg_addr)
        CC_OFS: n.rdata = {21'h000000, s.cc1};
        OS_OFS: n.rdata = {22'h000000, s.syncs, 4'h0, s.polh, s.poll, s.psyncs};
        EC_OFS: n.rdata = {26'h0000000, s.inhen, s.emd, 3'h0} |
                          {31'h00000000, s.en};
        ES_OFS: n.rdata = {30'h00000000, emergency_stop_input_n,
                           s.prot == PROT_ACTIVE};
        KEY_OFS: n.rdata = 32'h00000000;
        PM_OFS: n.rdata = {31'h00000000, s.pmode};
        default: n.rdata = 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s.cc1 <= CC_RST;
      s.cc2 <= CC_RST;
      s.trig_armed <= 1'b0;
      s.syncs <= TRG_NONE;
      s.psyncs <= PSY_ASYNC;
      s.polh <= 1'b0;
      s.poll <= 1'b0;
      s.en <= EC_EN_RST;
      s.inhen <= EC_INH_RST;
      s.emd <= EC_MD_RST;
      s.pmode <= 1'b0;
      s.prot <= PROT_NORMAL;
      // A low input right after reset counts as a fall
      s.emg_prev <= 1'b1;
      s.irq <= 1'b0;
      s.rdata <= 32'h00000000;
      s.up_out <= 3'h0;
      s.up_oe <= 3'h0;
      s.lo_out <= 3'h0;
      s.lo_oe <= 3'h0;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata = s.rdata;
  assign upper_out = s.up_out;
  assign upper_oe = s.up_oe;
  assign lower_out = s.lo_out;
  assign lower_oe = s.lo_oe;
  assign emergency_interrupt = s.irq;
  assign key_unlocked = unlocked;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  read_first_stage_a: assert property (
    reg_rd && reg_addr == CC_OFS |=> reg_rdata == {21'h000000, $past(s.cc1)})
    else $error("conduction read not first stage");

  second_stage_a: assert property (
    s.cc2 != $past(s.cc2) |-> $past(load))
    else $error("second stage changed outside load point");

  entry_force_a: assert property (
    s.en && s.emg_prev && !emergency_stop_input_n && s.prot == PROT_NORMAL
    |=> emergency_interrupt && s.prot == PROT_ACTIVE)
    else $error("emergency fall not acted on");

  irq_pulse_a: assert property (
    emergency_interrupt |=> !emergency_interrupt)
    else $error("interrupt longer than one cycle");

  hiz_mode_a: assert property (
    s.prot == PROT_ACTIVE && s.emd == EMD_ALL_Z && $stable(s.emd)
    |-> upper_oe == 3'h0 && lower_oe == 3'h0)
    else $error("outputs driven in all-off protection");

  low_input_hold_a: assert property (
    s.prot == PROT_ACTIVE && !emergency_stop_input_n |=> s.prot == PROT_ACTIVE)
    else $error("release while stop input low");

  release_cond_a: assert property (
    $past(s.prot) == PROT_ACTIVE && s.prot == PROT_NORMAL
    |-> $past(s.cc1 == CC_RST && s.cc2 == CC_RST && emergency_stop_input_n))
    else $error("release without zero conduction");

  key_clear_a: assert property (
    $fell(s.en) |-> $past(unlocked))
    else $error("protection disabled without key pair");

  status_read_a: assert property (
    reg_rd && reg_addr == ES_OFS
    |=> reg_rdata[ES_PROT] == ($past(s.prot) == PROT_ACTIVE) &&
        reg_rdata[ES_IN] == $past(emergency_stop_input_n))
    else $error("status read wrong");

  key_read_a: assert property (
    reg_rd && reg_addr == KEY_OFS |=> reg_rdata == 32'h00000000)
    else $error("key register not read as zero");

endmodule

// file: tb/mpe_gate_stage.sv
`timescale 1ns/1ps
// ****************************************************************
// Inverter gate stage seen from the six phase pins
// ****************************************************************
module mpe_gate_stage (
  // Pins from the block
  input wire logic [2:0] upper_out,
  input wire logic [2:0] upper_oe,
  input wire logic [2:0] lower_out,
  input wire logic [2:0] lower_oe,
  // Gate levels at the switches
  output logic [2:0] gate_hi,
  output logic [2:0] gate_lo
);
  // Gate inputs carry pull-downs, so a released pin turns its switch off
  assign gate_hi = upper_out & upper_oe;
  assign gate_lo = lower_out & lower_oe;
endmodule

// file: tb/motor_phase_output_emergency_stop_test.sv
`timescale 1ns/1ps
module motor_phase_output_emergency_stop_test;
  import mpe_pkg::*;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pwm_run = 1'b0;
  logic carrier_bottom = 1'b0;
  logic carrier_peak = 1'b0;
  logic update_trigger_a = 1'b0;
  logic update_trigger_b = 1'b0;
  logic [2:0] pwm_upper = 3'h5;
  logic [2:0] pwm_lower = 3'h3;
  logic emergency_stop_input_n = 1'b1;
  logic tool_break = 1'b0;
  logic ovv_key_used = 1'b0;
  logic [31:0] reg_rdata;
  logic [2:0] upper_out, upper_oe, lower_out, lower_oe, gate_hi, gate_lo;
  logic emergency_interrupt, key_unlocked;
  logic [31:0] rv;
  logic [10:0] prv, v;
  int err_count = 0;
  int cmp_count = 0;

  always #2.5 sys_clk = ~sys_clk;

  mpe_top uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_run(pwm_run),
    .carrier_bottom(carrier_bottom), .carrier_peak(carrier_peak),
    .update_trigger_a(update_trigger_a), .update_trigger_b(update_trigger_b),
    .pwm_upper(pwm_upper), .pwm_lower(pwm_lower),
    .emergency_stop_input_n(emergency_stop_input_n), .tool_break(tool_break),
    .ovv_key_used(ovv_key_used), .upper_out(upper_out), .upper_oe(upper_oe),
    .lower_out(lower_out), .lower_oe(lower_oe), .emergency_interrupt(emergency_interrupt),
    .key_unlocked(key_unlocked));

  mpe_gate_stage gate (.upper_out(upper_out), .upper_oe(upper_oe), .lower_out(lower_out),
    .lower_oe(lower_oe), .gate_hi(gate_hi), .gate_lo(gate_lo));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Always a full word, never split bytes
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(string n, logic [7:0] a, logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
  endtask

  task automatic pulse(int k);
    @(posedge sys_clk);
    carrier_bottom <= (k == 0);
    carrier_peak <= (k == 1);
    update_trigger_a <= (k == 2);
    update_trigger_b <= (k == 3);
    ovv_key_used <= (k == 4);
    @(posedge sys_clk);
    {carrier_bottom, carrier_peak, update_trigger_a, update_trigger_b, ovv_key_used} <= 5'h00;
  endtask

  function automatic logic [5:0] pins(logic [10:0] cc, logic pol);
    logic [2:0] u, l;
    logic [1:0] oc;
    for (int i = 0; i < 3; i++) begin
      oc = cc[2*i+:2];
      u[i] = cc[8+i] ? (oc != 2'b01) & pwm_upper[i] : oc[1];
      l[i] = cc[8+i] ? (oc != 2'b10) & pwm_lower[i] : oc[0];
    end
    return {u, l} ^ {6{~pol}};
  endfunction

  task automatic pchk(string n, logic [10:0] cc, logic pol);
    repeat (4) @(posedge sys_clk);
    #1;
    chk(n, {26'h0, pins(cc, pol)}, {26'h0, upper_out, lower_out});
  endtask

  task automatic oechk(string n, logic [5:0] e);
    #1;
    chk(n, {26'h0, e}, {26'h0, upper_oe, lower_oe});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rchk("cc", CC_OFS, 32'h0);
    rchk("ec", EC_OFS, {26'h0, EC_INH_RST, EC_MD_RST, 2'b00, EC_EN_RST});
    rchk("es", ES_OFS, 32'h2);
    wr(KEY_OFS, 32'h77);
    rchk("key", KEY_OFS, 32'h0);
    rchk("unmapped", 8'h40, 32'h0);
    pchk("pins", 11'h0, 1'b0);
  endtask

  task automatic t_map();
    for (int p = 0; p < 2; p++) begin
      wr(OS_OFS, {28'h0, p[0], p[0], 2'b00});
      pwm_upper <= p[0] ? 3'h6 : 3'h1;
      for (int c = 0; c < 8; c++) begin
        v = {{3{c[2]}}, 2'b00, {3{c[1:0]}}};
        wr(CC_OFS, {21'h0, v});
        pchk("map", v, p[0]);
      end
    end
  endtask

  task automatic t_load();
    wr(OS_OFS, 32'hC);
    wr(CC_OFS, 32'h0);
    prv = 11'h0;
    pwm_run <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(OS_OFS, 32'hC | s);
      v = ~prv & 11'h03F;
      wr(CC_OFS, 32'hFFFF_F8C0 | v);
      rchk("cc_rd", CC_OFS, {21'h0, v});
      pchk("ld_none", (s == 0) ? v : prv, 1'b1);
      pulse(1);
      pchk("ld_peak", (s == 0 || s > 1) ? v : prv, 1'b1);
      pulse(0);
      pchk("ld_bot", v, 1'b1);
      prv = v;
    end
    for (int t = 1; t < 3; t++) begin
      wr(OS_OFS, (t << 8) | 32'hD);
      v = ~prv & 11'h03F;
      wr(CC_OFS, {21'h0, v});
      pulse(0);
      pchk("trg_wait", prv, 1'b1);
      pulse(1 + t);
      pulse(0);
      pchk("trg_ld", v, 1'b1);
      prv = v;
    end
    // Reserved trigger code must load like no trigger, at the bottom alone
    wr(OS_OFS, 32'h30D);
    wr(CC_OFS, 32'h15);
    pchk("rsv_wait", prv, 1'b1);
    pulse(0);
    pchk("rsv_ld", 11'h015, 1'b1);
    @(posedge sys_clk);
    pwm_run <= 1'b0;
    wr(OS_OFS, 32'hC);
  endtask

  task automatic t_emg();
    for (int m = 0; m < 4; m++) begin
      wr(EC_OFS, 32'h21 | (m << 3));
      wr(CC_OFS, 32'h700);
      pchk("pre", 11'h700, 1'b1);
      @(posedge sys_clk);
      emergency_stop_input_n <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("irq", 32'h1, {31'h0, emergency_interrupt});
      @(posedge sys_clk);
      #1;
      chk("irq_end", 32'h0, {31'h0, emergency_interrupt});
      oechk("oe_emg", m == 1 ? 6'h38 : m == 2 ? 6'h07 : 6'h00);
      rchk("es_low", ES_OFS, 32'h1);
      wr(CC_OFS, 32'h0);
      repeat (4) @(posedge sys_clk);
      wr(EC_OFS, 32'h23 | (m << 3));
      rchk("rel_low", ES_OFS, 32'h1);
      @(posedge sys_clk);
      emergency_stop_input_n <= 1'b1;
      wr(CC_OFS, 32'h1);
      repeat (4) @(posedge sys_clk);
      wr(EC_OFS, 32'h23 | (m << 3));
      rchk("rel_busy", ES_OFS, 32'h3);
      wr(CC_OFS, 32'h0);
      repeat (4) @(posedge sys_clk);
      wr(EC_OFS, 32'h23 | (m << 3));
      rchk("rel_ok", ES_OFS, 32'h2);
      repeat (3) @(posedge sys_clk);
      oechk("oe_back", 6'h3F);
    end
  endtask

  task automatic t_key();
    wr(EC_OFS, 32'h38);
    rchk("en_locked", EC_OFS, 32'h39);
    wr(KEY_OFS, 32'h5A);
    wr(KEY_OFS, 32'hA5);
    #1;
    chk("unlk", 32'h1, {31'h0, key_unlocked});
    wr(EC_OFS, 32'h38);
    rchk("en_clr", EC_OFS, 32'h38);
    chk("unlk_used", 32'h0, {31'h0, key_unlocked});
    @(posedge sys_clk);
    emergency_stop_input_n <= 1'b0;
    rchk("es_off", ES_OFS, 32'h0);
    @(posedge sys_clk);
    emergency_stop_input_n <= 1'b1;
    wr(EC_OFS, 32'h39);
    wr(KEY_OFS, 32'h5A);
    wr(CC_OFS, 32'h0);
    wr(KEY_OFS, 32'hA5);
    #1;
    chk("unlk_abort", 32'h0, {31'h0, key_unlocked});
    wr(KEY_OFS, 32'h5A);
    wr(KEY_OFS, 32'hA5);
    #1;
    chk("unlk_again", 32'h1, {31'h0, key_unlocked});
    pulse(4);
    #1;
    chk("unlk_ovv", 32'h0, {31'h0, key_unlocked});
  endtask

  task automatic t_break();
    wr(CC_OFS, 32'h3F);
    wr(PM_OFS, 32'h1);
    tool_break <= 1'b1;
    repeat (4) @(posedge sys_clk);
    oechk("brk_z", 6'h00);
    chk("brk_gate", 32'h0, {26'h0, gate_hi, gate_lo});
    wr(PM_OFS, 32'h0);
    repeat (4) @(posedge sys_clk);
    oechk("brk_drv", 6'h3F);
    chk("brk_lvl", 32'h0, {26'h0, upper_out, lower_out});
    @(posedge sys_clk);
    tool_break <= 1'b0;
    pchk("brk_end", 11'h3F, 1'b1);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_map();
    t_load();
    t_emg();
    t_key();
    t_break();
    close_out();
  end

  initial begin
    #200000;
    err_count++;
    close_out();
  end
endmodule
